// File: hw/msv_regulation.sv
/*
 * Speed/voltage regulation set-up with soft start/stop, inrush timing and
 * stall blanking. Settings arrive from the device register file on the core
 * clock; the two documented registers are held here with write strobes.
 * Sense inputs are digitised codes already on the core clock.
 */
// Overview of operation
// - Mode 10b selects speed regulation, 11b voltage regulation of the setpoint.
// - Setpoint is 8 bits; 00h zero speed, FFh top of selected speed scale.
// - Speed mode drives measured ripple speed (max 255) toward the setpoint.
// - Voltage mode: 0 means 0 V, 255 about 42.67 V.
// - Voltage setpoint 227 stands for 38 V.
// - Speed scale codes give multipliers 16, 32, 64, 128 on speed value.
// - Conductance scale codes give factors 2, 64, 1024, 8192.
// - Back-emf scale codes give 24 times 2 to the 8, 9, 12, 13.
// - Sense select 0 uses filtered output voltage, 1 uses duty times supply.
// - Soft ramp enable acts only in mode 10b or 11b.
// - Soft start ramps toward target over inrush time with loop-made duty.
// - Direction change while running soft-stops, then soft-starts the other way.
// - Both host bridge bits at 0 soft-stop, then outputs go high impedance.
// - Setpoint written to 00h soft-stops down to zero.
// - Inrush time also blanks stall detection after startup.
// - Without soft ramp, inrush spans 5 ms at 0000h to 6.7 s; reset 1 s.
// - With soft ramp, ramp time is inrush setting times setpoint.
// - In regulation the duty is generated internally; manual duty select stays 0.
// - Duty rises below target, falls above, and is 100% if target exceeds supply in mode 11b.
`timescale 1ns/1ps
`default_nettype none
module msv_regulation #(
    parameter int INRUSH_BASE_CYCLES = msv_pkg::INRUSH_BASE_CYC,
    parameter int INRUSH_LSB_CYCLES = msv_pkg::INRUSH_LSB_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register file side
    input wire msv_pkg::msv_cfg_t cfg,
    input wire logic setpoint_wr,
    input wire logic [7:0] setpoint_wdata,
    input wire logic inrush_wr,
    input wire logic [15:0] inrush_wdata,
    input wire logic host_bridge_input_one,
    input wire logic host_bridge_input_two,
    input wire logic [7:0] inverse_resistance,
    input wire logic [7:0] back_emf_constant,
    // Sense codes
    input wire logic [7:0] measured_speed,
    input wire logic [7:0] filtered_out_voltage,
    input wire logic [7:0] supply_voltage,
    // Register readback
    output logic [7:0] target_setpoint,
    output logic [15:0] inrush_time_setting,
    output logic [7:0] duty_read,
    output logic [14:0] speed_rad_s,
    output logic [21:0] conductance_product,
    output logic [25:0] emf_product,
    output logic setpoint_above_vm_max,
    // Loop and bridge side
    output logic [7:0] ramp_target,
    output logic stall_blank,
    output logic regulating,
    output logic analog_sense_en,
    output logic [1:0] filter_cutoff_sel,
    output msv_pkg::msv_bridge_t bridge
);
    logic rst_meta;
    logic rst_sync;
    msv_pkg::msv_state_t state;
    msv_pkg::msv_state_t next_state;
    logic dir_rev;
    logic [31:0] step_cnt;
    logic [31:0] blank_cnt;
    logic [8:0] loop_div;
    logic [7:0] pwm_cnt;
    logic [7:0] next_ramp;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Mode decode and command decode
    wire reg_speed = (cfg.reg_mode == msv_pkg::MODE_SPEED);
    wire reg_voltage = (cfg.reg_mode == msv_pkg::MODE_VOLTAGE);
    wire reg_active = (reg_speed || reg_voltage) && !cfg.manual_duty_select;
    wire soft_active = reg_active && cfg.soft_ramp_en;
    wire drive_cmd = host_bridge_input_one ^ host_bridge_input_two;
    wire cmd_rev = host_bridge_input_two;
    wire brake_cmd = host_bridge_input_one && host_bridge_input_two;
    wire stop_cmd = !drive_cmd || (target_setpoint == msv_pkg::SETPOINT_ZERO);
    wire dir_change = drive_cmd && (cmd_rev != dir_rev);
    wire start_go = reg_active && !stop_cmd;
    wire [31:0] inrush_cycles = 32'(INRUSH_BASE_CYCLES)
        + 32'(inrush_time_setting) * 32'(INRUSH_LSB_CYCLES);
    // One ramp step per inrush interval gives setting times setpoint overall
    wire step_tick = (step_cnt >= inrush_cycles - 32'h1);
    wire loop_tick = (loop_div == 9'(msv_pkg::LOOP_UPDATE_CYC - 1));
    wire [15:0] duty_vm = 16'(duty_read) * 16'(supply_voltage);
    wire [7:0] feedback = reg_speed ? measured_speed
        : (cfg.voltage_sense_filter_select ? duty_vm[15:8] : filtered_out_voltage);
    wire over_supply = reg_voltage && (ramp_target > supply_voltage);
    wire running = (state != msv_pkg::ST_IDLE);

    // Documented registers
    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            target_setpoint <= msv_pkg::SETPOINT_ZERO;
            inrush_time_setting <= msv_pkg::INRUSH_RESET;
        end else begin
            if (setpoint_wr)
                target_setpoint <= setpoint_wdata;
            if (inrush_wr)
                inrush_time_setting <= inrush_wdata;
        end
    end

    always_comb begin
        next_state = state;
        next_ramp = ramp_target;
        unique case (state)
            msv_pkg::ST_IDLE: begin
                next_ramp = msv_pkg::SETPOINT_ZERO;
                if (start_go) begin
                    next_state = soft_active ? msv_pkg::ST_RAMP_UP : msv_pkg::ST_RUN;
                    next_ramp = soft_active ? msv_pkg::SETPOINT_ZERO : target_setpoint;
                end
            end
            msv_pkg::ST_RAMP_UP: begin
                if (!reg_active) begin
                    next_state = msv_pkg::ST_IDLE;
                end else if (stop_cmd || dir_change) begin
                    next_state = msv_pkg::ST_RAMP_DOWN;
                end else if (ramp_target >= target_setpoint) begin
                    next_state = msv_pkg::ST_RUN;
                    next_ramp = target_setpoint;
                end else if (step_tick) begin
                    next_ramp = ramp_target + 8'h01;
                end
            end
            msv_pkg::ST_RUN: begin
                if (!reg_active || ((stop_cmd || dir_change) && !soft_active))
                    next_state = msv_pkg::ST_IDLE;
                else if (stop_cmd || dir_change)
                    next_state = msv_pkg::ST_RAMP_DOWN;
                else
                    next_ramp = target_setpoint;
            end
            msv_pkg::ST_RAMP_DOWN: begin
                if (!reg_active || ramp_target == msv_pkg::SETPOINT_ZERO)
                    next_state = msv_pkg::ST_IDLE;
                else if (step_tick)
                    next_ramp = ramp_target - 8'h01;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= msv_pkg::ST_IDLE;
            ramp_target <= msv_pkg::SETPOINT_ZERO;
            dir_rev <= 1'b0;
        end else begin
            state <= next_state;
            ramp_target <= next_ramp;
            if (state == msv_pkg::ST_IDLE && start_go)
                dir_rev <= cmd_rev;
        end
    end

    // Ramp step timer restarts on every step and outside the ramp states
    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync)
            step_cnt <= 32'h0;
        else if (state == msv_pkg::ST_IDLE || state == msv_pkg::ST_RUN || step_tick)
            step_cnt <= 32'h0;
        else
            step_cnt <= step_cnt + 32'h1;
    end

    // Stall blank: inrush interval from start, held for the whole soft start
    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            blank_cnt <= 32'h0;
            stall_blank <= 1'b0;
        end else if (state == msv_pkg::ST_IDLE && start_go) begin
            blank_cnt <= inrush_cycles;
            stall_blank <= 1'b1;
        end else begin
            if (blank_cnt != 32'h0)
                blank_cnt <= blank_cnt - 32'h1;
            stall_blank <= (blank_cnt > 32'h1) || (next_state == msv_pkg::ST_RAMP_UP);
        end
    end

    // Loop update enable and duty integrator
    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            loop_div <= 9'h000;
            duty_read <= 8'h00;
        end else begin
            loop_div <= loop_tick ? 9'h000 : loop_div + 9'h001;
            if (!running)
                duty_read <= 8'h00;
            else if (over_supply)
                duty_read <= msv_pkg::DUTY_FULL;
            else if (loop_tick && feedback < ramp_target && duty_read != msv_pkg::DUTY_FULL)
                duty_read <= duty_read + 8'h01;
            else if (loop_tick && feedback > ramp_target && duty_read != 8'h00)
                duty_read <= duty_read - 8'h01;
        end
    end

    // Bridge drive: on time drives per direction, off time recirculates low
    wire pwm_on = (duty_read == msv_pkg::DUTY_FULL) || (pwm_cnt < duty_read);
    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            pwm_cnt <= 8'h00;
            bridge <= '{out1_high: 1'b0, out1_low: 1'b0, out2_high: 1'b0, out2_low: 1'b0, hiz: 1'b1};
        end else begin
            pwm_cnt <= pwm_cnt + 8'h01;
            if (running) begin
                bridge.out1_high <= pwm_on && !dir_rev;
                bridge.out2_high <= pwm_on && dir_rev;
                bridge.out1_low <= !pwm_on || dir_rev;
                bridge.out2_low <= !pwm_on || !dir_rev;
                bridge.hiz <= 1'b0;
            end else begin
                bridge.out1_high <= 1'b0;
                bridge.out2_high <= 1'b0;
                bridge.out1_low <= brake_cmd && reg_active;
                bridge.out2_low <= brake_cmd && reg_active;
                bridge.hiz <= !(brake_cmd && reg_active);
            end
        end
    end

    // Scaled parameters for the estimator and loop
    logic [13:0] cond_scale;
    logic [4:0] emf_shift;
    always_comb begin
        unique case (cfg.conductance_scale_select)
            2'h0: cond_scale = msv_pkg::COND_SCALE_0;
            2'h1: cond_scale = msv_pkg::COND_SCALE_1;
            2'h2: cond_scale = msv_pkg::COND_SCALE_2;
            2'h3: cond_scale = msv_pkg::COND_SCALE_3;
        endcase
        unique case (cfg.emf_constant_scale_select)
            2'h0: emf_shift = 5'(msv_pkg::EMF_SHIFT_0);
            2'h1: emf_shift = 5'(msv_pkg::EMF_SHIFT_1);
            2'h2: emf_shift = 5'(msv_pkg::EMF_SHIFT_2);
            2'h3: emf_shift = 5'(msv_pkg::EMF_SHIFT_3);
        endcase
    end
    wire [14:0] speed_scaled = 15'(measured_speed) << (msv_pkg::SPEED_SCALE_BASE_SHIFT + cfg.speed_scale_select);
    wire [17:0] emf_scale = msv_pkg::EMF_SCALE_BASE << emf_shift;

    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            speed_rad_s <= 15'h0000;
            conductance_product <= 22'h000000;
            emf_product <= 26'h0000000;
            setpoint_above_vm_max <= 1'b0;
            regulating <= 1'b0;
            analog_sense_en <= 1'b0;
            filter_cutoff_sel <= 2'h0;
        end else begin
            speed_rad_s <= speed_scaled;
            conductance_product <= 22'(inverse_resistance) * 22'(cond_scale);
            emf_product <= 26'(back_emf_constant) * 26'(emf_scale);
            // Codes above 227 ask for more than the supply can reach
            setpoint_above_vm_max <= reg_voltage && (target_setpoint > msv_pkg::SETPOINT_VM_MAX);
            regulating <= reg_active;
            analog_sense_en <= reg_voltage && !cfg.voltage_sense_filter_select;
            filter_cutoff_sel <= cfg.output_filter_cutoff;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync);

    property p_leave_when_off;
        !reg_active && running |=> state == msv_pkg::ST_IDLE;
    endproperty
    a_leave_when_off: assert property (p_leave_when_off) else $error("left regulation without stopping");
    property p_no_soft_start;
        state == msv_pkg::ST_IDLE && start_go && !soft_active |=> state == msv_pkg::ST_RUN && ramp_target == $past(target_setpoint);
    endproperty
    a_no_soft_start: assert property (p_no_soft_start) else $error("ramp used without soft enable");
    property p_zero_soft_stop;
        state == msv_pkg::ST_RUN && soft_active && target_setpoint == 8'h00 |=> state == msv_pkg::ST_RAMP_DOWN;
    endproperty
    a_zero_soft_stop: assert property (p_zero_soft_stop) else $error("zero setpoint did not soft stop");
    property p_dir_soft_stop;
        state == msv_pkg::ST_RUN && soft_active && dir_change && target_setpoint != 8'h00 |=> state == msv_pkg::ST_RAMP_DOWN;
    endproperty
    a_dir_soft_stop: assert property (p_dir_soft_stop) else $error("direction change did not soft stop");
    property p_hiz_after_stop;
        state == msv_pkg::ST_RAMP_DOWN && ramp_target == 8'h00 && !drive_cmd && !brake_cmd |-> ##2 bridge.hiz;
    endproperty
    a_hiz_after_stop: assert property (p_hiz_after_stop) else $error("outputs not released after soft stop");
    property p_linear_step;
        state == msv_pkg::ST_RAMP_UP && reg_active && !stop_cmd && !dir_change && step_tick && ramp_target < target_setpoint
            |=> ramp_target == $past(ramp_target) + 8'h01;
    endproperty
    a_linear_step: assert property (p_linear_step) else $error("ramp step not one count");
    property p_full_duty;
        running && over_supply |=> duty_read == 8'hFF;
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("duty not full above supply");
    property p_blank_on_start;
        state == msv_pkg::ST_IDLE && start_go |=> stall_blank && blank_cnt == $past(inrush_cycles);
    endproperty
    a_blank_on_start: assert property (p_blank_on_start) else $error("stall blank not started");
    property p_speed_scale;
        ##1 speed_rad_s == (15'($past(measured_speed)) << (4 + $past(cfg.speed_scale_select)));
    endproperty
    a_speed_scale: assert property (p_speed_scale) else $error("speed scaling wrong");

    c_ramp_done: cover property (state == msv_pkg::ST_RAMP_UP ##1 state == msv_pkg::ST_RUN);
    c_soft_stop_end: cover property (state == msv_pkg::ST_RAMP_DOWN ##1 state == msv_pkg::ST_IDLE);
    c_dir_reverse: cover property (state == msv_pkg::ST_RUN && dir_change && soft_active);
endmodule : msv_regulation
`default_nettype wire

// File: include/msv_pkg.sv
/*
 * Shared constants and carrier types for the speed/voltage regulation
 * set-up block. Assumes a 25 MHz core clock and an 8-bit setpoint domain.
 */
`default_nettype none
package msv_pkg;
    // Regulation mode select codes
    localparam logic [1:0] MODE_SPEED = 2'h2;
    localparam logic [1:0] MODE_VOLTAGE = 2'h3;
    // Setpoint encoding
    localparam logic [7:0] SETPOINT_ZERO = 8'h00;
    localparam logic [7:0] SETPOINT_FULL = 8'hFF;
    localparam logic [7:0] SETPOINT_VM_MAX = 8'hE3;
    localparam int VOLT_FULL_MV = 42670;
    // Speed scale: multiplier is 16 shifted by the select code
    localparam int SPEED_SCALE_BASE_SHIFT = 4;
    // Conductance scale factors
    localparam logic [13:0] COND_SCALE_0 = 14'h0002;
    localparam logic [13:0] COND_SCALE_1 = 14'h0040;
    localparam logic [13:0] COND_SCALE_2 = 14'h0400;
    localparam logic [13:0] COND_SCALE_3 = 14'h2000;
    // Back-emf scale: 24 shifted by 8, 9, 12 or 13
    localparam logic [17:0] EMF_SCALE_BASE = 18'h00018;
    localparam int EMF_SHIFT_0 = 8;
    localparam int EMF_SHIFT_1 = 9;
    localparam int EMF_SHIFT_2 = 12;
    localparam int EMF_SHIFT_3 = 13;
    // Inrush time: base plus one step per setting count
    localparam int CLK_PERIOD_NS = 40;
    localparam int INRUSH_BASE_NS = 5000000;
    localparam int INRUSH_LSB_NS = 102400;
    localparam int INRUSH_BASE_CYC = INRUSH_BASE_NS / CLK_PERIOD_NS;
    localparam int INRUSH_LSB_CYC = INRUSH_LSB_NS / CLK_PERIOD_NS;
    localparam logic [15:0] INRUSH_RESET = 16'h25F5;
    // Loop update rate follows the 80 kHz sampling of the sense path
    localparam int LOOP_UPDATE_NS = 12500;
    localparam int LOOP_UPDATE_CYC = LOOP_UPDATE_NS / CLK_PERIOD_NS;
    localparam logic [7:0] DUTY_FULL = 8'hFF;

    typedef struct packed {
        logic [1:0] reg_mode;
        logic soft_ramp_en;
        logic manual_duty_select;
        logic [1:0] speed_scale_select;
        logic [1:0] conductance_scale_select;
        logic [1:0] emf_constant_scale_select;
        logic voltage_sense_filter_select;
        logic [1:0] output_filter_cutoff;
    } msv_cfg_t;

    typedef struct packed {
        logic out1_high;
        logic out1_low;
        logic out2_high;
        logic out2_low;
        logic hiz;
    } msv_bridge_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RAMP_UP = 2'b01,
        ST_RUN = 2'b11,
        ST_RAMP_DOWN = 2'b10
    } msv_state_t;
endpackage : msv_pkg
`default_nettype wire

// File: test/msv_motor_model.sv
/*
 * Behavioural brushed DC motor seen through the H-bridge outputs.
 * Assumes the bridge struct of the regulation block on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module msv_motor_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Bridge and supply
    input wire msv_pkg::msv_bridge_t bridge,
    input wire logic [7:0] supply_voltage,
    // Sense codes
    output logic [7:0] measured_speed,
    output logic [7:0] filtered_out_voltage
);
    logic [3:0] tick;
    wire logic fwd = bridge.out1_high && bridge.out2_low;
    wire logic rev = bridge.out2_high && bridge.out1_low;
    wire logic drive = !bridge.hiz && (fwd || rev);
    // Slow mechanics: one code step per 16 cycles, so PWM on-time sets the average
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tick <= 4'h0;
            measured_speed <= 8'h00;
            filtered_out_voltage <= 8'h00;
        end else begin
            tick <= tick + 4'h1;
            if (tick == 4'hF && drive && measured_speed != 8'hFF) begin
                measured_speed <= measured_speed + 8'h01;
            end else if (tick == 4'hF && !drive && measured_speed != 8'h00) begin
                measured_speed <= measured_speed - 8'h01;
            end
            if (tick == 4'hF && drive && filtered_out_voltage < supply_voltage) begin
                filtered_out_voltage <= filtered_out_voltage + 8'h01;
            end else if (tick == 4'hF && !drive && filtered_out_voltage != 8'h00) begin
                filtered_out_voltage <= filtered_out_voltage - 8'h01;
            end
        end
    end
endmodule : msv_motor_model
`default_nettype wire

// File: test/tb.sv
/*
 * Self-checking bench for the regulation set-up block with a motor model.
 * Assumes shortened inrush parameters so ramps take tens of cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [1:0] sel; logic [1:0] mode; logic vss; logic [7:0] val; logic [7:0] sp;
        logic [14:0] spd; logic [21:0] cond; logic [25:0] emf; logic above; logic analog; logic reg_on;
    } msv_row_t;
    localparam int BASE = 20;
    localparam int LSB = 4;
    msv_row_t rows [4] = '{
        '{2'h0, 2'h2, 1'b0, 8'hFF, 8'hFF, 15'h0FF0, 22'h0001FE, 26'h017E800, 1'b0, 1'b0, 1'b1},
        '{2'h1, 2'h3, 1'b0, 8'h0F, 8'hE3, 15'h01E0, 22'h0003C0, 26'h002D000, 1'b0, 1'b1, 1'b1},
        '{2'h2, 2'h3, 1'b1, 8'h01, 8'hE4, 15'h0040, 22'h000400, 26'h0018000, 1'b1, 1'b0, 1'b1},
        '{2'h3, 2'h1, 1'b0, 8'hFF, 8'hFF, 15'h7F80, 22'h1FE000, 26'h2FD0000, 1'b0, 1'b0, 1'b0}};
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    msv_pkg::msv_cfg_t cfg = '0;
    logic setpoint_wr = 1'b0;
    logic [7:0] setpoint_wdata = 8'h00;
    logic inrush_wr = 1'b0;
    logic [15:0] inrush_wdata = 16'h0000;
    logic b1 = 1'b0;
    logic b2 = 1'b0;
    logic [7:0] val = 8'h00;
    logic use_row = 1'b1;
    logic [7:0] supply = 8'hF0;
    logic [7:0] model_speed, fov, target_setpoint, duty_read, ramp_target, last_rt;
    logic [15:0] inrush_time_setting;
    logic [14:0] speed_rad_s;
    logic [21:0] conductance_product;
    logic [25:0] emf_product;
    logic setpoint_above_vm_max, stall_blank, regulating, analog_sense_en;
    logic [1:0] filter_cutoff_sel;
    msv_pkg::msv_bridge_t bridge;
    int fails = 0;
    int check_count = 0;
    int cyc, t_step, gap, nchg;
    logic soft_mon = 1'b0;
    wire logic [7:0] meas = use_row ? val : model_speed;
    always #20 sys_clk = ~sys_clk;
    msv_regulation #(.INRUSH_BASE_CYCLES(BASE), .INRUSH_LSB_CYCLES(LSB)) DUT (.sys_clk(sys_clk), .rstn(rstn),
        .cfg(cfg), .setpoint_wr(setpoint_wr), .setpoint_wdata(setpoint_wdata), .inrush_wr(inrush_wr),
        .inrush_wdata(inrush_wdata), .host_bridge_input_one(b1), .host_bridge_input_two(b2),
        .inverse_resistance(val), .back_emf_constant(val), .measured_speed(meas),
        .filtered_out_voltage(fov), .supply_voltage(supply), .target_setpoint(target_setpoint),
        .inrush_time_setting(inrush_time_setting), .duty_read(duty_read), .speed_rad_s(speed_rad_s),
        .conductance_product(conductance_product), .emf_product(emf_product),
        .setpoint_above_vm_max(setpoint_above_vm_max), .ramp_target(ramp_target), .stall_blank(stall_blank),
        .regulating(regulating), .analog_sense_en(analog_sense_en), .filter_cutoff_sel(filter_cutoff_sel),
        .bridge(bridge));
    msv_motor_model motor (.sys_clk(sys_clk), .rstn(rstn), .bridge(bridge), .supply_voltage(supply),
        .measured_speed(model_speed), .filtered_out_voltage(fov));
    task automatic chk(input logic [25:0] got, input logic [25:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            fails++;
            $display("CHECK FAILED %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_rng
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : step
    task automatic wr_sp(input logic [7:0] d);
        setpoint_wdata = d;
        setpoint_wr = 1'b1;
        step(1);
        setpoint_wr = 1'b0;
    endtask : wr_sp
    task automatic wr_in(input logic [15:0] d);
        inrush_wdata = d;
        inrush_wr = 1'b1;
        step(1);
        inrush_wr = 1'b0;
        t_step = BASE + int'(d) * LSB;
    endtask : wr_in
    task automatic wait_rt(input logic [7:0] exp, output int n);
        n = 0;
        while (ramp_target !== exp && n < 3000) begin
            step(1);
            n++;
        end
    endtask : wait_rt
    task automatic wrap_up;
        if (fails == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    // Watches soft ramps 5 ns after each rising edge so it never races the negedge driver
    always @(posedge sys_clk) begin
        #5;
        gap = gap + 1;
        if (soft_mon && ramp_target !== last_rt) begin
            chk(26'(ramp_target === last_rt + 8'h01 || ramp_target === last_rt - 8'h01), 26'h1);
            if (nchg > 0) chk_rng(gap, t_step, t_step);
            nchg = nchg + 1;
        end
        if (ramp_target !== last_rt) gap = 0;
        last_rt = ramp_target;
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        fails++;
        wrap_up();
    end
    initial begin
        step(5);
        chk(26'(inrush_time_setting), 26'h25F5);
        chk(26'({bridge.hiz, target_setpoint, stall_blank}), 26'h200);
        rstn = 1'b1;
        step(4);
        for (int i = 0; i < 4; i++) begin
            cfg.reg_mode = rows[i].mode;
            cfg.speed_scale_select = rows[i].sel;
            cfg.conductance_scale_select = rows[i].sel;
            cfg.emf_constant_scale_select = rows[i].sel;
            cfg.output_filter_cutoff = rows[i].sel;
            cfg.voltage_sense_filter_select = rows[i].vss;
            val = rows[i].val;
            wr_sp(rows[i].sp);
            step(3);
            chk(26'(target_setpoint), 26'(rows[i].sp));
            chk(26'(speed_rad_s), 26'(rows[i].spd));
            chk(26'(conductance_product), 26'(rows[i].cond));
            chk(emf_product, rows[i].emf);
            chk(26'({setpoint_above_vm_max, analog_sense_en}), 26'({rows[i].above, rows[i].analog}));
            chk(26'({regulating, filter_cutoff_sel}), 26'({rows[i].reg_on, rows[i].sel}));
        end
        cfg = '0;
        cfg.reg_mode = 2'h1;
        cfg.soft_ramp_en = 1'b1;
        b1 = 1'b1;
        step(6);
        chk(26'({bridge.hiz, ramp_target}), 26'h100);
        cfg.reg_mode = msv_pkg::MODE_SPEED;
        cfg.soft_ramp_en = 1'b0;
        b1 = 1'b0;
        wr_in(16'h0002);
        wr_sp(8'h0A);
        step(2);
        chk(26'(inrush_time_setting), 26'h0002);
        b1 = 1'b1;
        step(2);
        chk(26'({ramp_target, stall_blank}), 26'h015);
        step(2);
        chk(26'(bridge.hiz), 26'h0);
        cyc = 4;
        while (stall_blank === 1'b1 && cyc < 1000) begin
            step(1);
            cyc++;
        end
        chk_rng(cyc, t_step, t_step + 3);
        cfg.manual_duty_select = 1'b1;
        step(4);
        chk(26'({regulating, bridge.hiz}), 26'h1);
        cfg.manual_duty_select = 1'b0;
        b1 = 1'b0;
        step(4);
        cfg.soft_ramp_en = 1'b1;
        wr_in(16'h0001);
        wr_sp(8'h04);
        step(1);
        nchg = 0;
        soft_mon = 1'b1;
        b1 = 1'b1;
        step(2 * t_step);
        chk(26'(stall_blank), 26'h1);
        wait_rt(8'h04, cyc);
        chk_rng(cyc + 2 * t_step, 4 * t_step - 2, 4 * t_step + 2);
        chk(26'({bridge.hiz, bridge.out2_high}), 26'h0);
        step(2);
        nchg = 0;
        b1 = 1'b0;
        b2 = 1'b1;
        wait_rt(8'h00, cyc);
        chk_rng(cyc, 4 * t_step - 2, 4 * t_step + 2);
        nchg = 0;
        wait_rt(8'h04, cyc);
        chk_rng(cyc, 4 * t_step - 4, 4 * t_step + 4);
        chk(26'(bridge.out1_high), 26'h0);
        nchg = 0;
        wr_sp(8'h00);
        wait_rt(8'h00, cyc);
        chk_rng(cyc, 4 * t_step - 3, 4 * t_step + 2);
        step(4);
        chk(26'(bridge.hiz), 26'h1);
        nchg = 0;
        wr_sp(8'h04);
        wait_rt(8'h04, cyc);
        nchg = 0;
        b2 = 1'b0;
        step(2 * t_step);
        chk(26'(bridge.hiz), 26'h0);
        wait_rt(8'h00, cyc);
        step(4);
        chk(26'(bridge.hiz), 26'h1);
        soft_mon = 1'b0;
        cfg.soft_ramp_en = 1'b0;
        use_row = 1'b0;
        wr_sp(8'h40);
        b1 = 1'b1;
        step(1000);
        chk(26'(duty_read > 8'h00), 26'h1);
        cfg.reg_mode = msv_pkg::MODE_VOLTAGE;
        supply = 8'h20;
        wr_sp(8'h80);
        step(4);
        chk(26'(duty_read), 26'h0FF);
        b2 = 1'b1;
        step(4);
        chk(26'({bridge.out1_low, bridge.out2_low, bridge.hiz}), 26'h6);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
